// ==== include/diag_log_pkg.sv ====
// Constants for the diagnostic log sector keeper
package diag_log_pkg;
   // --------------------------------------------------------------
   // Register map (byte addresses)
   // --------------------------------------------------------------
   localparam logic [7:0] REG_LOG_SEL = 8'h00;
   localparam logic [7:0] REG_PTR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_CHKSUM = 8'h10;
   // --------------------------------------------------------------
   // Log addresses and sector counts
   // --------------------------------------------------------------
   localparam logic [7:0] LOG_DIR = 8'h00;
   localparam logic [7:0] LOG_ERR = 8'h01;
   localparam logic [7:0] LOG_ST = 8'h06;
   localparam logic [7:0] LOG_SEL = 8'h09;
   localparam logic [7:0] LOG_VEND_LO = 8'h80;
   localparam logic [7:0] LOG_VEND_HI = 8'h9F;
   localparam logic [7:0] VEND_SECTORS = 8'h10;
   localparam logic [7:0] ONE_SECTOR = 8'h01;
   // --------------------------------------------------------------
   // Sector layout
   // --------------------------------------------------------------
   localparam int SECT_BYTES = 512;
   localparam logic [8:0] CHK_OFS = 9'h1FF;
   localparam logic [8:0] LAST_SUM = 9'h1FE;
   localparam logic [7:0] LOG_VERSION = 8'h01;
   localparam int ERR_RECS = 5;
   localparam int ERR_REC_BYTES = 90;
   localparam logic [8:0] ERR_REC_OFS = 9'h002;
   localparam logic [8:0] ERR_CNT_OFS = 9'h1C4;
   localparam int CMD_SNAP_BYTES = 12;
   localparam int CMD_TS_OFS = 8;
   localparam int ERR_SNAP_OFS = 60;
   localparam int ERR_VEND_OFS = 8;
   localparam int ERR_VEND_BYTES = 19;
   localparam int ERR_STATE_OFS = 27;
   localparam int ERR_HOURS_OFS = 28;
   localparam int ST_DESCS = 21;
   localparam int ST_DESC_BYTES = 24;
   localparam logic [8:0] ST_DESC_OFS = 9'h002;
   localparam logic [8:0] ST_IDX_OFS = 9'h1FC;
   localparam int ST_VEND_BYTES = 15;
   localparam logic [8:0] SEL_RW_END = 9'h052;
   localparam logic [8:0] SEL_LBA_OFS = 9'h1EC;
   localparam logic [8:0] SEL_SPAN_OFS = 9'h1F4;
   localparam logic [8:0] SEL_FLAG_OFS = 9'h1F6;
   localparam logic [8:0] SEL_PEND_OFS = 9'h1FC;
   localparam int FLAG_SCAN_REQ = 1;
   localparam int FLAG_SCAN_PEND = 3;
   localparam int FLAG_SCAN_ACT = 4;
   localparam logic [7:0] FLAG_HOST_MASK = 8'h07;
endpackage : diag_log_pkg

// ==== rtl/diag_log_sector_keeper.sv ====
// Diagnostic log sector keeper with AHB-Lite register port
`timescale 1ns/100ps
// Notes on behaviour
// - Log directory sits at log address zero, one 512-byte sector.
// - Directory opens with logging version word 01h.
// - Directory byte 2N is sector count of log N, then reserved byte.
// - Logs 80h to 9Fh report sixteen sectors each.
// - Summary error log byte 0 holds version 01h.
// - Five 90-byte records from 02h; index at 01h names newest, 1 to 5.
// - Two-byte error count at 1C4h saturates, never wraps.
// - Record is five 12-byte command snapshots then error snapshot at 3Ch.
// - Command snapshot: eight task-file bytes, then ms timestamp at 08h.
// - Error snapshot: registers 01h-07h, vendor 08h, state 1Bh, hours 1Ch.
// - State byte low nibble codes device condition at command arrival.
// - Self-test log: revision word, then 24-byte descriptors at n*24+2.
// - Descriptor: number, status, hours, checkpoint, failing LBA, vendor.
// - After 21 descriptors the oldest is overwritten, circularly.
// - Self-test index at 1FCh: 0 when empty, else newest 1 to 21.
// - Host writes and reads back five spans, bytes 02h to 51h.
// - Current LBA at 1ECh and current span at 1F4h are read-only.
// - Flags word at 1F6h: bit 1 requests off-line scan; 5-15 reserved.
// - Device shows bit 3 while scan pending, bit 4 while running.
// - Pending-time word at 1FCh is host writable and readable.
// - Multi-byte fields are stored least significant byte first.
// - Byte 1FFh makes all 512 bytes of a sector sum to zero.
module diag_log_sector_keeper #(
   parameter logic [15:0] ST_REVISION = 16'h0001 // Arbitrary value
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic err_stb,
   input wire logic [319:0] err_cmd_regs,
   input wire logic [159:0] err_cmd_ms,
   input wire logic [55:0] err_regs,
   input wire logic [151:0] err_vendor,
   input wire logic [7:0] err_state,
   input wire logic [15:0] err_hours,
   input wire logic st_stb,
   input wire logic [7:0] st_number,
   input wire logic [7:0] st_status,
   input wire logic [15:0] st_hours,
   input wire logic [7:0] st_checkpoint,
   input wire logic [31:0] st_lba,
   input wire logic [119:0] st_vendor,
   input wire logic [63:0] sel_cur_lba,
   input wire logic [15:0] sel_cur_span,
   input wire logic scan_pending,
   input wire logic scan_active,
   output logic [639:0] sel_spans,
   output logic sel_scan_req,
   output logic [15:0] sel_pend_time
);
   // --------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------
   localparam int ERR_REC_BYTES = diag_log_pkg::ERR_REC_BYTES;
   localparam int ST_DESC_BYTES = diag_log_pkg::ST_DESC_BYTES;
   logic [7:0] err_mem_q [diag_log_pkg::ERR_RECS][ERR_REC_BYTES];
   logic [7:0] err_mem_d [diag_log_pkg::ERR_RECS][ERR_REC_BYTES];
   logic [7:0] st_mem_q [diag_log_pkg::ST_DESCS][ST_DESC_BYTES];
   logic [7:0] st_mem_d [diag_log_pkg::ST_DESCS][ST_DESC_BYTES];
   logic [7:0] sel_mem_q [82];
   logic [7:0] sel_mem_d [82];
   logic [7:0] err_rec [ERR_REC_BYTES];
   logic [7:0] st_rec [ST_DESC_BYTES];
   logic [2:0] err_idx_q, err_idx_d;
   logic [15:0] err_cnt_q, err_cnt_d;
   logic [4:0] st_idx_q, st_idx_d;
   logic [7:0] flags_q, flags_d;
   logic [15:0] pend_q, pend_d;
   logic [63:0] lba_q;
   logic [15:0] span_q;
   logic spend_q, sact_q;
   logic [7:0] log_sel_q, log_sel_d;
   logic [8:0] ptr_q, ptr_d;
   // AHB state
   logic wr_q, wr_d;
   logic [1:0] rd_q, rd_d;
   logic [7:0] addr_q, addr_d;
   logic [31:0] hrdata_q, hrdata_d;
   // Checksum sweeper
   logic [8:0] sw_cnt_q, sw_cnt_d;
   logic [7:0] sw_acc_q, sw_acc_d;
   logic sw_dirty_q, sw_dirty_d;
   logic [7:0] chk_q, chk_d;
   logic chk_ok_q, chk_ok_d;
   logic [7:0] host_byte, sw_byte;
   logic data_wr, change;

   // --------------------------------------------------------------
   // Byte view of every sector
   // --------------------------------------------------------------
   function automatic logic [7:0] log_byte(input logic [7:0] ls, input logic [8:0] a);
      int r;
      int o;
      logic [7:0] b;
      r = 0;
      o = 0;
      b = 8'h00;
      if (a == diag_log_pkg::CHK_OFS) begin
         b = chk_q;
      end else if (ls == diag_log_pkg::LOG_DIR) begin
         if (a == 9'h000) begin
            b = diag_log_pkg::LOG_VERSION;
         end else if (a[0] == 1'b0) begin
            if (a[8:1] >= diag_log_pkg::LOG_VEND_LO && a[8:1] <= diag_log_pkg::LOG_VEND_HI) begin
               b = diag_log_pkg::VEND_SECTORS;
            end else if (a[8:1] == diag_log_pkg::LOG_ERR || a[8:1] == diag_log_pkg::LOG_ST
                  || a[8:1] == diag_log_pkg::LOG_SEL) begin
               b = diag_log_pkg::ONE_SECTOR;
            end
         end
      end else if (ls == diag_log_pkg::LOG_ERR) begin
         if (a == 9'h000) begin
            b = diag_log_pkg::LOG_VERSION;
         end else if (a == 9'h001) begin
            b = {5'h00, err_idx_q};
         end else if (a >= diag_log_pkg::ERR_REC_OFS && a < diag_log_pkg::ERR_CNT_OFS) begin
            r = int'(a - diag_log_pkg::ERR_REC_OFS) / ERR_REC_BYTES;
            o = int'(a - diag_log_pkg::ERR_REC_OFS) % ERR_REC_BYTES;
            b = err_mem_q[r][o];
         end else if (a == diag_log_pkg::ERR_CNT_OFS) begin
            b = err_cnt_q[7:0];
         end else if (a == diag_log_pkg::ERR_CNT_OFS + 9'h001) begin
            b = err_cnt_q[15:8];
         end
      end else if (ls == diag_log_pkg::LOG_ST) begin
         if (a == 9'h000) begin
            b = ST_REVISION[7:0];
         end else if (a == 9'h001) begin
            b = ST_REVISION[15:8];
         end else if (a >= diag_log_pkg::ST_DESC_OFS
               && int'(a) < diag_log_pkg::ST_DESCS * ST_DESC_BYTES + 2) begin
            r = int'(a - diag_log_pkg::ST_DESC_OFS) / ST_DESC_BYTES;
            o = int'(a - diag_log_pkg::ST_DESC_OFS) % ST_DESC_BYTES;
            b = st_mem_q[r][o];
         end else if (a == diag_log_pkg::ST_IDX_OFS) begin
            b = {3'h0, st_idx_q};
         end
      end else if (ls == diag_log_pkg::LOG_SEL) begin
         if (a < diag_log_pkg::SEL_RW_END) begin
            b = sel_mem_q[a[6:0]];
         end else if (a >= diag_log_pkg::SEL_LBA_OFS && a < diag_log_pkg::SEL_SPAN_OFS) begin
            b = lba_q[(a - diag_log_pkg::SEL_LBA_OFS) * 8 +: 8];
         end else if (a == diag_log_pkg::SEL_SPAN_OFS) begin
            b = span_q[7:0];
         end else if (a == diag_log_pkg::SEL_SPAN_OFS + 9'h001) begin
            b = span_q[15:8];
         end else if (a == diag_log_pkg::SEL_FLAG_OFS) begin
            b = {3'h0, sact_q, spend_q, flags_q[2:0]};
         end else if (a == diag_log_pkg::SEL_PEND_OFS) begin
            b = pend_q[7:0];
         end else if (a == diag_log_pkg::SEL_PEND_OFS + 9'h001) begin
            b = pend_q[15:8];
         end
      end
      return b;
   endfunction : log_byte

   assign host_byte = log_byte(log_sel_q, ptr_q);
   assign sw_byte = log_byte(log_sel_q, sw_cnt_q);

   // --------------------------------------------------------------
   // AHB-Lite slave
   // --------------------------------------------------------------
   // Reads take one wait state so that a preceding write is visible
   assign hreadyout = (rd_q != 2'd1);
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign data_wr = wr_q && (addr_q == diag_log_pkg::REG_DATA);

   always_comb begin
      wr_d = 1'b0;
      rd_d = (rd_q == 2'd1) ? 2'd2 : 2'd0;
      addr_d = addr_q;
      hrdata_d = hrdata_q;
      log_sel_d = log_sel_q;
      ptr_d = ptr_q;
      if (hsel && htrans[1] && hready) begin
         addr_d = {haddr[7:2], 2'b00};
         wr_d = hwrite;
         rd_d = hwrite ? 2'd0 : 2'd1;
      end
      if (wr_q) begin
         case (addr_q)
            diag_log_pkg::REG_LOG_SEL: log_sel_d = hwdata[7:0];
            diag_log_pkg::REG_PTR: ptr_d = hwdata[8:0];
            diag_log_pkg::REG_DATA: ptr_d = ptr_q + 9'h001;
            default: ;
         endcase
      end
      if (rd_q == 2'd1) begin
         case (addr_q)
            diag_log_pkg::REG_LOG_SEL: hrdata_d = {24'h0, log_sel_q};
            diag_log_pkg::REG_PTR: hrdata_d = {23'h0, ptr_q};
            diag_log_pkg::REG_DATA: begin
               hrdata_d = {24'h0, host_byte};
               ptr_d = ptr_q + 9'h001;
            end
            diag_log_pkg::REG_STATUS: hrdata_d = {19'h0, st_idx_q, 1'b0, err_idx_q, 3'h0, chk_ok_q};
            diag_log_pkg::REG_CHKSUM: hrdata_d = {24'h0, chk_q};
            default: hrdata_d = 32'h0000_0000;
         endcase
      end
   end

   // --------------------------------------------------------------
   // Log contents
   // --------------------------------------------------------------
   always_comb begin
      for (int s = 0; s < 5; s++) begin
         for (int b = 0; b < 8; b++) begin
            err_rec[s * diag_log_pkg::CMD_SNAP_BYTES + b] = err_cmd_regs[(s * 8 + b) * 8 +: 8];
         end
         for (int b = 0; b < 4; b++) begin
            err_rec[s * diag_log_pkg::CMD_SNAP_BYTES + diag_log_pkg::CMD_TS_OFS + b] =
               err_cmd_ms[s * 32 + b * 8 +: 8];
         end
      end
      err_rec[diag_log_pkg::ERR_SNAP_OFS] = 8'h00;
      for (int b = 0; b < 7; b++) begin
         err_rec[diag_log_pkg::ERR_SNAP_OFS + 1 + b] = err_regs[b * 8 +: 8];
      end
      for (int b = 0; b < diag_log_pkg::ERR_VEND_BYTES; b++) begin
         err_rec[diag_log_pkg::ERR_SNAP_OFS + diag_log_pkg::ERR_VEND_OFS + b] =
            err_vendor[b * 8 +: 8];
      end
      err_rec[diag_log_pkg::ERR_SNAP_OFS + diag_log_pkg::ERR_STATE_OFS] = err_state;
      err_rec[diag_log_pkg::ERR_SNAP_OFS + diag_log_pkg::ERR_HOURS_OFS] = err_hours[7:0];
      err_rec[diag_log_pkg::ERR_SNAP_OFS + diag_log_pkg::ERR_HOURS_OFS + 1] = err_hours[15:8];
      st_rec[0] = st_number;
      st_rec[1] = st_status;
      st_rec[2] = st_hours[7:0];
      st_rec[3] = st_hours[15:8];
      st_rec[4] = st_checkpoint;
      for (int b = 0; b < 4; b++) begin
         st_rec[5 + b] = st_lba[b * 8 +: 8];
      end
      for (int b = 0; b < diag_log_pkg::ST_VEND_BYTES; b++) begin
         st_rec[9 + b] = st_vendor[b * 8 +: 8];
      end
   end

   always_comb begin
      err_mem_d = err_mem_q;
      st_mem_d = st_mem_q;
      sel_mem_d = sel_mem_q;
      err_idx_d = err_idx_q;
      err_cnt_d = err_cnt_q;
      st_idx_d = st_idx_q;
      flags_d = flags_q;
      pend_d = pend_q;
      if (err_stb) begin
         err_idx_d = (err_idx_q == 3'd5 || err_idx_q == 3'd0) ? 3'd1 : err_idx_q + 3'd1;
         err_mem_d[err_idx_d - 3'd1] = err_rec;
         if (err_cnt_q != 16'hFFFF) begin
            err_cnt_d = err_cnt_q + 16'h0001;
         end
      end
      if (st_stb) begin
         st_idx_d = (st_idx_q == 5'd21) ? 5'd1 : st_idx_q + 5'd1;
         st_mem_d[st_idx_d - 5'd1] = st_rec;
      end
      if (data_wr && log_sel_q == diag_log_pkg::LOG_SEL) begin
         if (ptr_q < diag_log_pkg::SEL_RW_END) begin
            sel_mem_d[ptr_q[6:0]] = hwdata[7:0];
         end else if (ptr_q == diag_log_pkg::SEL_FLAG_OFS) begin
            flags_d = hwdata[7:0] & diag_log_pkg::FLAG_HOST_MASK;
         end else if (ptr_q == diag_log_pkg::SEL_PEND_OFS) begin
            pend_d[7:0] = hwdata[7:0];
         end else if (ptr_q == diag_log_pkg::SEL_PEND_OFS + 9'h001) begin
            pend_d[15:8] = hwdata[7:0];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 80; i++) begin
         sel_spans[i * 8 +: 8] = sel_mem_q[i + 2];
      end
   end
   assign sel_scan_req = flags_q[diag_log_pkg::FLAG_SCAN_REQ];
   assign sel_pend_time = pend_q;

   // --------------------------------------------------------------
   // Checksum sweeper
   // --------------------------------------------------------------
   // Walks bytes 0..510 of the selected log; any change in the
   // middle discards the pass, so a stale checksum is never marked good
   assign change = err_stb || st_stb || data_wr || (log_sel_d != log_sel_q)
      || (sel_cur_lba != lba_q) || (sel_cur_span != span_q)
      || (scan_pending != spend_q) || (scan_active != sact_q);

   always_comb begin
      sw_acc_d = sw_acc_q + sw_byte;
      sw_cnt_d = sw_cnt_q + 9'h001;
      sw_dirty_d = sw_dirty_q || change;
      chk_d = chk_q;
      chk_ok_d = chk_ok_q && !change;
      if (sw_cnt_q == diag_log_pkg::LAST_SUM) begin
         sw_cnt_d = 9'h000;
         sw_acc_d = 8'h00;
         sw_dirty_d = change;
         if (!sw_dirty_q && !change) begin
            chk_d = 8'h00 - (sw_acc_q + sw_byte);
            chk_ok_d = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int r = 0; r < diag_log_pkg::ERR_RECS; r++) begin
            for (int b = 0; b < ERR_REC_BYTES; b++) begin
               err_mem_q[r][b] <= 8'h00;
            end
         end
         for (int r = 0; r < diag_log_pkg::ST_DESCS; r++) begin
            for (int b = 0; b < ST_DESC_BYTES; b++) begin
               st_mem_q[r][b] <= 8'h00;
            end
         end
         for (int b = 0; b < 82; b++) begin
            sel_mem_q[b] <= 8'h00;
         end
         err_idx_q <= 3'd0;
         err_cnt_q <= 16'h0000;
         st_idx_q <= 5'd0;
         flags_q <= 8'h00;
         pend_q <= 16'h0000;
         lba_q <= 64'h0;
         span_q <= 16'h0000;
         spend_q <= 1'b0;
         sact_q <= 1'b0;
         log_sel_q <= 8'h00;
         ptr_q <= 9'h000;
         wr_q <= 1'b0;
         rd_q <= 2'd0;
         addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         sw_cnt_q <= 9'h000;
         sw_acc_q <= 8'h00;
         sw_dirty_q <= 1'b1;
         chk_q <= 8'h00;
         chk_ok_q <= 1'b0;
      end else begin
         err_mem_q <= err_mem_d;
         st_mem_q <= st_mem_d;
         sel_mem_q <= sel_mem_d;
         err_idx_q <= err_idx_d;
         err_cnt_q <= err_cnt_d;
         st_idx_q <= st_idx_d;
         flags_q <= flags_d;
         pend_q <= pend_d;
         lba_q <= sel_cur_lba;
         span_q <= sel_cur_span;
         spend_q <= scan_pending;
         sact_q <= scan_active;
         log_sel_q <= log_sel_d;
         ptr_q <= ptr_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         addr_q <= addr_d;
         hrdata_q <= hrdata_d;
         sw_cnt_q <= sw_cnt_d;
         sw_acc_q <= sw_acc_d;
         sw_dirty_q <= sw_dirty_d;
         chk_q <= chk_d;
         chk_ok_q <= chk_ok_d;
      end
   end
endmodule : diag_log_sector_keeper

// ==== tb/diag_log_checker.sv ====
// Concurrent checks on the log keeper bus port and host outputs
`timescale 1ns/100ps
module diag_log_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [639:0] sel_spans,
   input wire logic sel_scan_req,
   input wire logic [15:0] sel_pend_time
);
   // ------------------------------
   // Helper state and sequences
   // ------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic take;
   logic wr_dp_d;
   logic wr_dp_q;
   assign take = hsel && htrans[1] && hready;
   always_comb begin
      wr_dp_d = take && hwrite;
   end
   // Host-side outputs may only move after a write data phase
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_dp_q <= 1'b0;
      end else begin
         wr_dp_q <= wr_dp_d;
      end
   end
   sequence s_rd_take;
      take && !hwrite;
   endsequence
   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
   a_read_wait: assert property (s_rd_take |=> s_rd_answer) else $error("bad read wait");
   a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
   a_wait_cause: assert property (!hreadyout |-> $past(take && !hwrite))
      else $error("stall without read");
   a_rdata_hold: assert property ($past(hreadyout) |-> $stable(hrdata))
      else $error("hrdata moved");
   a_spans_quiet: assert property (!$past(wr_dp_q) |-> $stable(sel_spans))
      else $error("spans moved");
   a_scan_quiet: assert property (!$past(wr_dp_q) |-> $stable(sel_scan_req))
      else $error("scan request moved");
   a_pend_quiet: assert property (!$past(wr_dp_q) |-> $stable(sel_pend_time))
      else $error("pending time moved");
endmodule : diag_log_checker
bind diag_log_sector_keeper diag_log_checker u_chk (.mclk, .rst_n, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .hrdata, .sel_spans, .sel_scan_req, .sel_pend_time);

// ==== tb/host_bus_model.sv ====
// AHB-Lite host model moving log sector bytes one word access at a time
`timescale 1ns/100ps
module host_bus_model (
   input wire logic mclk,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   output logic hsel = 1'b0,
   output logic [31:0] haddr = 32'h0,
   output logic [1:0] htrans = 2'h0,
   output logic hwrite = 1'b0,
   output logic [2:0] hsize = 3'h2,
   output logic [31:0] hwdata = 32'h0
);
   // ------------------------------
   // Single word transfers
   // ------------------------------
   logic tmo = 1'b0;
   logic [31:0] rd_s;
   // Ready seen mid-cycle equals what the next rising edge samples
   task automatic wait_ready();
      logic ok;
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         ok = hreadyout;
         rd_s = hrdata;
         @(posedge mclk);
         n++;
      end while (ok !== 1'b1 && n < 40);
      if (ok !== 1'b1) begin
         tmo = 1'b1;
      end
   endtask : wait_ready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      r = rd_s;
   endtask : xfer
endmodule : host_bus_model

// ==== tb/tb_diag_log_sector_keeper.sv ====
// Self-checking bench for the diagnostic log sector keeper
`timescale 1ns/100ps
module tb_diag_log_sector_keeper;
   // ------------------------------
   // Stimulus, design and host
   // ------------------------------
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, sel_scan_req, err_stb = 1'b0, st_stb = 1'b0;
   logic [31:0] haddr, hwdata, hrdata, st_lba = 32'h0;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [319:0] err_cmd_regs = '0;
   logic [159:0] err_cmd_ms = '0;
   logic [55:0] err_regs = '0;
   logic [151:0] err_vendor = '0;
   logic [7:0] err_state = 8'h00, st_number = 8'h00, st_status = 8'h00, st_checkpoint = 8'h00;
   logic [15:0] err_hours = 16'h0, st_hours = 16'h0, sel_cur_span = 16'h0, sel_pend_time;
   logic [119:0] st_vendor = '0;
   logic [63:0] sel_cur_lba = '0;
   logic scan_pending = 1'b0, scan_active = 1'b0;
   logic [639:0] sel_spans;
   int num_errors = 0, cmp_count = 0;
   diag_log_sector_keeper DUT (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .err_stb, .err_cmd_regs, .err_cmd_ms,
      .err_regs, .err_vendor, .err_state, .err_hours, .st_stb, .st_number, .st_status,
      .st_hours, .st_checkpoint, .st_lba, .st_vendor, .sel_cur_lba, .sel_cur_span,
      .scan_pending, .scan_active, .sel_spans, .sel_scan_req, .sel_pend_time);
   host_bus_model host (.mclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata);
   initial begin
      forever #5 mclk = ~mclk;
   end
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      host.xfer(w, a, d, r);
      if (host.tmo) begin
         num_errors++;
         end_of_test();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, {24'h0, d}, r);
   endtask : wr
   task automatic status(output logic [31:0] r);
      bus(1'b0, diag_log_pkg::REG_STATUS, 32'h0, r);
   endtask : status
   task automatic sel(input logic [7:0] lg, input logic [8:0] p);
      logic [31:0] r;
      wr(diag_log_pkg::REG_LOG_SEL, lg);
      bus(1'b1, diag_log_pkg::REG_PTR, {23'h0, p}, r);
   endtask : sel
   // Reads the byte at the pointer and compares it
   task automatic rb(input logic [7:0] exp);
      logic [31:0] r;
      bus(1'b0, diag_log_pkg::REG_DATA, 32'h0, r);
      chk(r[7:0], exp);
   endtask : rb
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_dir();
      logic [8:0] p[9] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h00C, 9'h012, 9'h100, 9'h13E, 9'h1FE};
      logic [7:0] e[9] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h10, 8'h10, 8'h00};
      for (int i = 0; i < 9; i++) begin
         sel(diag_log_pkg::LOG_DIR, p[i]);
         rb(e[i]);
      end
      $display("Directory test done");
   endtask : t_dir
   task automatic t_err();
      logic [31:0] r;
      logic [8:0] p[9] = '{9'h000, 9'h001, 9'h002, 9'h00A, 9'h03F, 9'h045, 9'h059, 9'h05C, 9'h0B3};
      logic [7:0] e[9] = '{8'h01, 8'h01, 8'hC6, 8'h06, 8'hE6, 8'h50, 8'hA5, 8'hC2, 8'hA1};
      status(r);
      chk(r[6:4], 32'h0);
      for (int k = 1; k <= 6; k++) begin
         err_cmd_regs[7:0] <= 8'hC0 + 8'(k);
         err_cmd_ms[31:0] <= 32'h11223300 + 32'(k);
         err_regs <= {8'h50, 40'h0, 8'hE0 + 8'(k)};
         err_state <= 8'hA0 + 8'(k - 1);
         err_hours <= 16'h0100 + 16'(k);
         err_stb <= 1'b1;
         @(posedge mclk);
         err_stb <= 1'b0;
         status(r);
         chk(r[6:4], 32'((k - 1) % 5 + 1));
      end
      for (int i = 0; i < 9; i++) begin
         sel(diag_log_pkg::LOG_ERR, p[i]);
         rb(e[i]);
      end
      rb(8'h02);
      sel(diag_log_pkg::LOG_ERR, 9'h1C4);
      rb(8'h06);
      rb(8'h00);
      $display("Error log test done");
   endtask : t_err
   task automatic t_st();
      logic [31:0] r;
      logic [7:0] d[11] = '{8'h01, 8'h00, 8'h16, 8'h02, 8'h70, 8'h02, 8'h02, 8'h42, 8'hD2,
         8'hC3, 8'hB2};
      status(r);
      chk(r[12:8], 32'h0);
      for (int k = 1; k <= 22; k++) begin
         st_number <= 8'(k);
         st_status <= 8'h70;
         st_hours <= 16'h0200 + 16'(k);
         st_checkpoint <= 8'h40 + 8'(k);
         st_lba <= 32'hA1B2C3D0 + 32'(k);
         st_stb <= 1'b1;
         @(posedge mclk);
         st_stb <= 1'b0;
         status(r);
         chk(r[12:8], (k > 21) ? 32'h1 : 32'(k));
      end
      for (int i = 0; i < 11; i++) begin
         sel(diag_log_pkg::LOG_ST, (i < 3) ? 9'(i) : 9'(i + 23));
         rb(d[i]);
      end
      sel(diag_log_pkg::LOG_ST, 9'h1FC);
      rb(8'h01);
      $display("Self-test log test done");
   endtask : t_st
   task automatic t_sel();
      logic [639:0] e;
      sel(diag_log_pkg::LOG_SEL, 9'h002);
      for (int i = 0; i < 80; i++) begin
         e[i * 8 +: 8] = 8'(i) ^ 8'h5A;
         wr(diag_log_pkg::REG_DATA, e[i * 8 +: 8]);
      end
      // Last byte lands at the edge the write task returns on
      @(posedge mclk);
      for (int i = 0; i < 20; i++) begin
         chk(sel_spans[i * 32 +: 32], e[i * 32 +: 32]);
      end
      sel(diag_log_pkg::LOG_SEL, 9'h002);
      for (int i = 0; i < 80; i++) begin
         rb(e[i * 8 +: 8]);
      end
      sel(diag_log_pkg::LOG_SEL, 9'h1F6);
      wr(diag_log_pkg::REG_DATA, 8'h02);
      wr(diag_log_pkg::REG_DATA, 8'hFF);
      chk(sel_scan_req, 32'h1);
      scan_pending <= 1'b1;
      sel(diag_log_pkg::LOG_SEL, 9'h1F6);
      rb(8'h0A);
      rb(8'h00);
      scan_pending <= 1'b0;
      scan_active <= 1'b1;
      sel(diag_log_pkg::LOG_SEL, 9'h1F6);
      rb(8'h12);
      sel(diag_log_pkg::LOG_SEL, 9'h1FC);
      wr(diag_log_pkg::REG_DATA, 8'h34);
      wr(diag_log_pkg::REG_DATA, 8'h12);
      @(posedge mclk);
      chk(sel_pend_time, 32'h1234);
      sel_cur_lba <= 64'h0807060504030201;
      sel_cur_span <= 16'h0003;
      sel(diag_log_pkg::LOG_SEL, 9'h1EC);
      wr(diag_log_pkg::REG_DATA, 8'hFF);
      sel(diag_log_pkg::LOG_SEL, 9'h1EC);
      for (int i = 0; i < 10; i++) begin
         rb((i < 8) ? 8'(i + 1) : 8'(i == 8 ? 3 : 0));
      end
      $display("Selective log test done");
   endtask : t_sel
   task automatic t_chk();
      logic [7:0] lg[4] = '{diag_log_pkg::LOG_DIR, diag_log_pkg::LOG_ERR, diag_log_pkg::LOG_ST,
         diag_log_pkg::LOG_SEL};
      logic [31:0] r;
      logic [7:0] s;
      int n;
      for (int g = 0; g < 4; g++) begin
         sel(lg[g], 9'h000);
         n = 0;
         do begin
            status(r);
            n++;
         end while (r[0] !== 1'b1 && n < 400);
         if (r[0] !== 1'b1) begin
            num_errors++;
            end_of_test();
         end
         s = 8'h00;
         for (int i = 0; i < 512; i++) begin
            bus(1'b0, diag_log_pkg::REG_DATA, 32'h0, r);
            s = s + r[7:0];
         end
         chk(s, 32'h0);
      end
      wr(8'h18, 8'hFF);
      bus(1'b0, 8'h14, 32'h0, r);
      chk(r, 32'h0);
      $display("Checksum test done");
   endtask : t_chk
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_dir();
      t_err();
      t_st();
      t_sel();
      t_chk();
      end_of_test();
   end
endmodule : tb_diag_log_sector_keeper
